/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import ebcc_pkg::*;
  // ****************
  // Bench signals
  // ****************
  logic clk_sys_in = 0, rstn_in = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0, tck = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
  logic [1:0] bresp, rresp;
  logic awr, wrdy, bv, arr, rv, bexp;
  logic [7:0] tlow = 0, tdn = 0, lds = 0;
  logic [3:0] ws = 4'hF;
  ebcc_chan_ctrl_t cc;
  ebcc_loop_ctrl_t lc;
  int n_errors = 0, compares = 0, cyc = 0;
  // Clock, toggling transmit clocks
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) tck <= ~tck;
  ebcc_top #(.HOLD_CYC(4)) i_ebcc_top (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(aw), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(w),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(ar),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .tx_clock_pin_in({8{tck}} & ~tlow),
    .tx_negative_data_pin_in(tdn), .loop_detect_status_in(lds),
    .chan_ctrl_out(cc), .loop_ctrl_out(lc), .bank_expanded_out(bexp));
  // ****************
  // Tasks
  // ****************
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write, address and data together
  task wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
    awa <= {25'h0, idx, 2'h0};
    wd <= {24'h0, d};
    aw <= 1;
    w <= 1;
    br <= 1;
    do begin
      @(posedge clk_sys_in);
      if (awr) aw <= 0;
      if (wrdy) w <= 0;
    end while (!bv);
    br <= 0;
    chk("bresp", bresp, er);
    @(posedge clk_sys_in);
  endtask
  // Bus read with data and response check
  task rd(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
    ara <= {25'h0, idx, 2'h0};
    ar <= 1;
    rr <= 1;
    do begin
      @(posedge clk_sys_in);
      if (arr) ar <= 0;
    end while (!rv);
    rr <= 0;
    chk("rresp", rresp, er);
    chk("rdata", rdat, {24'h0, d});
    @(posedge clk_sys_in);
  endtask
  // Verdict
  task tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1;
    @(posedge clk_sys_in);
    rd(IDX_BANK_PTR, 8'h00, RESP_OKAY);
    chk("bank", bexp, 0);
    rd(IDX_RX_PDN, 8'h00, RESP_SLVERR);
    wr(IDX_BANK_PTR, BANK_EXPANDED, RESP_OKAY);
    chk("bank", bexp, 1);
    wr(IDX_BANK_PTR, 8'h55, RESP_OKAY);
    rd(IDX_BANK_PTR, BANK_EXPANDED, RESP_OKAY);
    for (int i = 0; i < 8; i++) rd(5'(i), 8'h00, RESP_OKAY);
    rd(5'h10, 8'h00, RESP_SLVERR); // Unmapped
    wr(IDX_RX_PDN, 8'h01, RESP_OKAY);
    wr(IDX_EQUALIZER, 8'h80, RESP_OKAY);
    chk("rx_pdn", cc.rx_powerdown, 8'h01);
    chk("equal", cc.rx_equalizer, 8'h80);
    // Lane 0 strobe off stores nothing
    ws <= 4'h0;
    wr(IDX_RX_PDN, 8'hFE, RESP_OKAY);
    ws <= 4'hF;
    rd(IDX_RX_PDN, 8'h01, RESP_OKAY);
    wr(IDX_TX_PDN, 8'h02, RESP_OKAY);
    chk("tx_pdn", cc.tx_powerdown, 8'h02);
    chk("drv_en", cc.tx_driver_en, 8'hFD);
    // Lane 3 transmit clock stuck low
    tlow <= 8'h08;
    repeat (20) @(posedge clk_sys_in);
    chk("tx_pdn", cc.tx_powerdown, 8'h0A);
    chk("drv_en", cc.tx_driver_en, 8'hF5);
    tlow <= 8'h00;
    repeat (20) @(posedge clk_sys_in);
    chk("tx_pdn", cc.tx_powerdown, 8'h02);
    wr(IDX_SINGLE_RAIL, 8'h0F, RESP_OKAY);
    wr(IDX_RECOVERY, 8'h01, RESP_OKAY);
    wr(IDX_LINE_CODE, 8'h02, RESP_OKAY);
    wr(IDX_ZERO_RUN, 8'h0F, RESP_OKAY);
    wr(IDX_VIOLATION, 8'h04, RESP_OKAY);
    chk("single", cc.single_rail, 8'h0E);
    chk("recov", cc.recovery_active, 8'hFE);
    chk("ami", cc.ami_sel, 8'h02);
    chk("zero", cc.zero_run_detect, 8'h0C);
    chk("viol", cc.violation_detect, 8'h08);
    // Negative-data pins pick rails where the force bit is clear
    tdn <= 8'h30;
    repeat (5) @(posedge clk_sys_in);
    chk("single", cc.single_rail, 8'h3E);
    // Every activate and deactivate length, reserved bits kept zero
    for (int k = 0; k < 4; k++) begin
      wr(IDX_LOOP_CFG, 8'h10 | 8'(k << 2) | 8'(3 - k), RESP_OKAY);
      chk("act", lc.activate_code_mask, 8'(8'hFF << (3 - k)));
      chk("deact", lc.deactivate_code_mask, 8'(8'hFF << k));
    end
    chk("auto", lc.auto_loop_en, 1);
    chk("detect", lc.loop_code_detect_en, 0);
    wr(IDX_LOOP_CFG, 8'h20, RESP_OKAY);
    chk("detect", lc.loop_code_detect_en, 1);
    chk("auto", lc.auto_loop_en, 0);
    // Five-bit codes with top bits copied into the low bits
    wr(IDX_ACT_CODE, 8'hC6, RESP_OKAY);
    wr(IDX_DEACT_CODE, 8'h94, RESP_OKAY);
    chk("actv", lc.activate_code_value, 8'hC6);
    chk("deactv", lc.deactivate_code_value, 8'h94);
    // Status change flags only masked channels while detection is on
    wr(IDX_LOOP_MASK, 8'h03, RESP_OKAY);
    lds <= 8'h07;
    repeat (5) @(posedge clk_sys_in);
    rd(IDX_LOOP_FLAG, 8'h03, RESP_OKAY);
    rd(IDX_LOOP_STATUS, 8'h07, RESP_OKAY);
    rd(IDX_LOOP_FLAG, 8'h00, RESP_OKAY);
    wr(IDX_LOOP_CFG, 8'h00, RESP_OKAY);
    lds <= 8'h00;
    repeat (5) @(posedge clk_sys_in);
    rd(IDX_LOOP_FLAG, 8'h00, RESP_OKAY);
    wr(IDX_BANK_PTR, BANK_PRIMARY, RESP_OKAY);
    chk("bank", bexp, 0);
    rd(IDX_LOOP_CFG, 8'h00, RESP_SLVERR);
    tally_and_finish;
  end
endmodule

/* rtl/ebcc_chan_ctrl.sv */
`timescale 1ns/1ps
module ebcc_chan_ctrl #(
  parameter int HOLD_CYC = ebcc_pkg::TCLK_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Configuration and pins
  input wire ebcc_pkg::ebcc_chan_cfg_t cfg_in,
  input wire logic [7:0] tx_clock_pin_in,
  input wire logic [7:0] tx_negative_data_pin_in,
  // Resolved controls
  output ebcc_pkg::ebcc_chan_ctrl_t ctrl_out
);
  import ebcc_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  // Elaboration check
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("HOLD_CYC must be at least one");
  end

  ebcc_chan_ctrl_t ctrl_next;
  logic [7:0] held_low;

  // ***********************************************
  // Per-channel pin sync and control resolution
  // ***********************************************
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    logic [1:0] tclk_sync_reg;
    logic [1:0] tdn_sync_reg;
    logic [CW-1:0] low_cnt_reg;
    logic sr;
    logic ami;

    // Two-flop synchronisers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        tclk_sync_reg <= 2'h0;
        tdn_sync_reg <= 2'h0;
      end else begin
        tclk_sync_reg <= {tclk_sync_reg[0], tx_clock_pin_in[n]};
        tdn_sync_reg <= {tdn_sync_reg[0], tx_negative_data_pin_in[n]};
      end
    end

    // Count cycles of a low transmit clock
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        low_cnt_reg <= '0;
      end else if (tclk_sync_reg[1]) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg != CW'(HOLD_CYC)) begin
        low_cnt_reg <= low_cnt_reg + CW'(1);
      end
    end

    assign held_low[n] = (low_cnt_reg == CW'(HOLD_CYC));
    // Force needs recovery on, else dual rail; with force clear the pin picks rails
    assign sr = cfg_in.single_rail_force[n] ? ~cfg_in.recovery_bypass[n]
                                            : tdn_sync_reg[1];
    assign ami = sr & ~cfg_in.recovery_bypass[n] & cfg_in.line_code_sel[n];
    assign ctrl_next.single_rail[n] = sr;
    assign ctrl_next.ami_sel[n] = ami;
    assign ctrl_next.recovery_active[n] = ~cfg_in.recovery_bypass[n];
    assign ctrl_next.rx_powerdown[n] = cfg_in.rx_powerdown[n];
    assign ctrl_next.tx_powerdown[n] = cfg_in.tx_powerdown[n] | held_low[n];
    assign ctrl_next.tx_driver_en[n] = ~(cfg_in.tx_powerdown[n] | held_low[n]);
    assign ctrl_next.zero_run_detect[n] = cfg_in.zero_run_detect_en[n] & sr & ~ami;
    assign ctrl_next.violation_detect[n] = ~cfg_in.violation_detect_off[n] & sr & ~ami;
    assign ctrl_next.rx_equalizer[n] = cfg_in.rx_equalizer_en[n];
  end

  // Output register
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out <= ctrl_next;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  property p_tx_pd_bit;
    ((ctrl_out.tx_powerdown & $past(cfg_in.tx_powerdown)) == $past(cfg_in.tx_powerdown))
      && ((ctrl_out.tx_powerdown & ctrl_out.tx_driver_en) == 8'h00);
  endproperty
  a_tx_pd_bit: assert property (p_tx_pd_bit) else $error("tx power-down bit ignored");

  property p_tx_clk_low;
    ((ctrl_out.tx_powerdown & $past(held_low)) == $past(held_low));
  endproperty
  a_tx_clk_low: assert property (p_tx_clk_low) else $error("tx clock low ignored");

  property p_force_rail;
    ((ctrl_out.single_rail & $past(cfg_in.single_rail_force & ~cfg_in.recovery_bypass))
      == $past(cfg_in.single_rail_force & ~cfg_in.recovery_bypass));
  endproperty
  a_force_rail: assert property (p_force_rail) else $error("single rail not forced");

  property p_ami_gate;
    ((ctrl_out.ami_sel & ~ctrl_out.single_rail) == 8'h00)
      && ((ctrl_out.ami_sel & ~ctrl_out.recovery_active) == 8'h00);
  endproperty
  a_ami_gate: assert property (p_ami_gate) else $error("AMI outside single rail");
endmodule

/* rtl/ebcc_pkg.sv */
// Behaviour
// - Pointer write 0x00 selects primary bank; 0xAA selects expanded bank.
// - After reset the pointer reads zero and selects the primary bank.
// - Clear force bit lets the negative-data pin pick rails; set forces single rail while recovery is on.
// - Line code bit applies only in single rail with recovery on; 1 means AMI.
// - Recovery bypass bit 0 keeps recovery running, 1 disables it; resets to 0.
// - Set receiver power-down bit powers that receiver down; resets to zero.
// - Set transmitter power-down bit powers it down and floats its line driver.
// - Transmit clock pin held low also powers the transmitter down.
// - Zero-run detect bit enables excessive-zero detection in single rail decoding without AMI.
// - Violation detect runs in single rail without AMI when its bit is 0, stops when 1.
// - Set equalizer bit enables that receiver's equalizer.
// - Loopback config bit 5 enables inband loop code detection; resets to 0.
// - Loopback config bit 4 enables automatic inband loopback.
// - Activate length field bits 3:2 picks compared code bits 7:3 up to 7:0.
// - Deactivate length field bits 1:0 picks compared code bits likewise.
// - Loopback config is one global register shared by all eight channels.
// - Loop flag sets on status change only with its mask and detect enable set.
package ebcc_pkg;
  localparam int NUM_CH = 8;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_SINGLE_RAIL = 5'h00;
  localparam logic [4:0] IDX_LINE_CODE = 5'h01;
  localparam logic [4:0] IDX_RECOVERY = 5'h02;
  localparam logic [4:0] IDX_RX_PDN = 5'h03;
  localparam logic [4:0] IDX_TX_PDN = 5'h04;
  localparam logic [4:0] IDX_ZERO_RUN = 5'h05;
  localparam logic [4:0] IDX_VIOLATION = 5'h06;
  localparam logic [4:0] IDX_EQUALIZER = 5'h07;
  localparam logic [4:0] IDX_LOOP_CFG = 5'h08;
  localparam logic [4:0] IDX_ACT_CODE = 5'h09;
  localparam logic [4:0] IDX_DEACT_CODE = 5'h0A;
  localparam logic [4:0] IDX_LOOP_STATUS = 5'h0B;
  localparam logic [4:0] IDX_LOOP_MASK = 5'h0C;
  localparam logic [4:0] IDX_LOOP_FLAG = 5'h0D;
  localparam logic [4:0] IDX_BANK_PTR = 5'h1F;
  // Bank pointer codes and reset values
  localparam logic [7:0] BANK_PRIMARY = 8'h00;
  localparam logic [7:0] BANK_EXPANDED = 8'hAA;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_LOOP_CFG = 6'h00;
  // Loopback config field positions
  localparam int LCFG_DETECT_BIT = 5;
  localparam int LCFG_AUTO_BIT = 4;
  localparam int LCFG_ACT_LSB = 2;
  localparam int LCFG_DEACT_LSB = 0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Transmit clock hold-low time before power-down
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCLK_HOLD_NS = 2000;
  localparam int TCLK_HOLD_CYC = (TCLK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Software-written per-channel vectors
  typedef struct packed {
    logic [7:0] single_rail_force;
    logic [7:0] line_code_sel;
    logic [7:0] recovery_bypass;
    logic [7:0] rx_powerdown;
    logic [7:0] tx_powerdown;
    logic [7:0] zero_run_detect_en;
    logic [7:0] violation_detect_off;
    logic [7:0] rx_equalizer_en;
  } ebcc_chan_cfg_t;

  // Resolved per-channel controls to the line datapath
  typedef struct packed {
    logic [7:0] single_rail;
    logic [7:0] ami_sel;
    logic [7:0] recovery_active;
    logic [7:0] rx_powerdown;
    logic [7:0] tx_powerdown;
    logic [7:0] tx_driver_en;
    logic [7:0] zero_run_detect;
    logic [7:0] violation_detect;
    logic [7:0] rx_equalizer;
  } ebcc_chan_ctrl_t;

  // Global inband loopback controls
  typedef struct packed {
    logic [7:0] activate_code_value;
    logic [7:0] deactivate_code_value;
    logic [7:0] activate_code_mask;
    logic [7:0] deactivate_code_mask;
    logic loop_code_detect_en;
    logic auto_loop_en;
  } ebcc_loop_ctrl_t;
endpackage

/* rtl/ebcc_top.sv */
`timescale 1ns/1ps
module ebcc_top #(
  parameter int HOLD_CYC = ebcc_pkg::TCLK_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Line pins and detector status
  input wire logic [7:0] tx_clock_pin_in,
  input wire logic [7:0] tx_negative_data_pin_in,
  input wire logic [7:0] loop_detect_status_in,
  // Controls to the datapath
  output ebcc_pkg::ebcc_chan_ctrl_t chan_ctrl_out,
  output ebcc_pkg::ebcc_loop_ctrl_t loop_ctrl_out,
  output logic bank_expanded_out
);
  import ebcc_pkg::*;

  // ***********************************************
  // Storage
  // ***********************************************
  logic [7:0] bank_ptr_reg;
  ebcc_chan_cfg_t cfg_reg;
  logic [5:0] loop_cfg_reg;
  logic [7:0] act_code_reg;
  logic [7:0] deact_code_reg;
  logic [7:0] loop_mask_reg;
  logic [7:0] loop_flag_reg;
  logic [7:0] loop_flag_next;
  logic [7:0] det_sync0_reg;
  logic [7:0] det_sync1_reg;
  logic [7:0] det_prev_reg;

  // Write channel state
  logic aw_have_reg;
  logic w_have_reg;
  logic [31:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic rd_status;

  // Compare mask from a code length field
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    unique case (len)
      2'h0: len_mask = 8'hF8;
      2'h1: len_mask = 8'hFC;
      2'h2: len_mask = 8'hFE;
      2'h3: len_mask = 8'hFF;
    endcase
  endfunction

  // Address decode against the current bank
  function automatic logic addr_hit(input logic [31:0] addr, input logic expanded);
    logic [4:0] idx;
    idx = addr[6:2];
    addr_hit = 1'b0;
    if (addr[31:7] == 25'h0) begin
      if (idx == IDX_BANK_PTR) begin
        addr_hit = 1'b1;
      end else if (expanded && idx <= IDX_LOOP_FLAG) begin
        addr_hit = 1'b1;
      end
    end
  endfunction

  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid_out;
  assign wr_hit = addr_hit(aw_addr_reg, bank_expanded_out);
  assign rd_hit = addr_hit(s_axi_araddr_in, bank_expanded_out);
  assign rd_status = s_axi_arvalid_in & s_axi_arready_out & rd_hit
                     & (s_axi_araddr_in[6:2] == IDX_LOOP_STATUS);

  // ***********************************************
  // AXI4-Lite write path
  // ***********************************************
  // Address capture; ready returns after the response
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_awready_out <= 1'b1;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 32'h0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  // Data capture; only the low lane carries register data
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_wready_out <= 1'b1;
      w_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in[7:0];
      w_lane0_reg <= s_axi_wstrb_in[0];
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  // Response once both halves are in
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ***********************************************
  // Register updates
  // ***********************************************
  // Bank pointer takes only the two legal codes
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_ptr_reg <= BANK_PRIMARY;
      bank_expanded_out <= 1'b0;
    end else if (do_write && wr_hit && w_lane0_reg && aw_addr_reg[6:2] == IDX_BANK_PTR) begin
      if (w_data_reg == BANK_PRIMARY || w_data_reg == BANK_EXPANDED) begin
        bank_ptr_reg <= w_data_reg;
        bank_expanded_out <= (w_data_reg == BANK_EXPANDED);
      end
    end
  end

  // Expanded bank configuration
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_reg <= '0;
      loop_cfg_reg <= RST_LOOP_CFG;
      act_code_reg <= RST_BYTE;
      deact_code_reg <= RST_BYTE;
      loop_mask_reg <= RST_BYTE;
    end else if (do_write && wr_hit && w_lane0_reg && bank_expanded_out) begin
      unique case (aw_addr_reg[6:2])
        IDX_SINGLE_RAIL: cfg_reg.single_rail_force <= w_data_reg;
        IDX_LINE_CODE: cfg_reg.line_code_sel <= w_data_reg;
        IDX_RECOVERY: cfg_reg.recovery_bypass <= w_data_reg;
        IDX_RX_PDN: cfg_reg.rx_powerdown <= w_data_reg;
        IDX_TX_PDN: cfg_reg.tx_powerdown <= w_data_reg;
        IDX_ZERO_RUN: cfg_reg.zero_run_detect_en <= w_data_reg;
        IDX_VIOLATION: cfg_reg.violation_detect_off <= w_data_reg;
        IDX_EQUALIZER: cfg_reg.rx_equalizer_en <= w_data_reg;
        IDX_LOOP_CFG: loop_cfg_reg <= w_data_reg[5:0];
        IDX_ACT_CODE: act_code_reg <= w_data_reg;
        IDX_DEACT_CODE: deact_code_reg <= w_data_reg;
        IDX_LOOP_MASK: loop_mask_reg <= w_data_reg;
        default: ;
      endcase
    end
  end

  // ***********************************************
  // Loop detector status and flags
  // ***********************************************
  // Status synchroniser and edge history
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      det_sync0_reg <= 8'h00;
      det_sync1_reg <= 8'h00;
      det_prev_reg <= 8'h00;
    end else begin
      det_sync0_reg <= loop_detect_status_in;
      det_sync1_reg <= det_sync0_reg;
      det_prev_reg <= det_sync1_reg;
    end
  end

  // Set on gated change wins over clear by status read
  always_comb begin
    loop_flag_next = loop_flag_reg;
    if (rd_status) begin
      loop_flag_next = 8'h00;
    end
    loop_flag_next = loop_flag_next | ((det_sync1_reg ^ det_prev_reg) & loop_mask_reg
                     & {8{loop_cfg_reg[LCFG_DETECT_BIT]}});
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loop_flag_reg <= RST_BYTE;
    end else begin
      loop_flag_reg <= loop_flag_next;
    end
  end

  // ***********************************************
  // Read path
  // ***********************************************
  always_comb begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr_in[6:2])
      IDX_SINGLE_RAIL: rd_byte = cfg_reg.single_rail_force;
      IDX_LINE_CODE: rd_byte = cfg_reg.line_code_sel;
      IDX_RECOVERY: rd_byte = cfg_reg.recovery_bypass;
      IDX_RX_PDN: rd_byte = cfg_reg.rx_powerdown;
      IDX_TX_PDN: rd_byte = cfg_reg.tx_powerdown;
      IDX_ZERO_RUN: rd_byte = cfg_reg.zero_run_detect_en;
      IDX_VIOLATION: rd_byte = cfg_reg.violation_detect_off;
      IDX_EQUALIZER: rd_byte = cfg_reg.rx_equalizer_en;
      IDX_LOOP_CFG: rd_byte = {2'h0, loop_cfg_reg};
      IDX_ACT_CODE: rd_byte = act_code_reg;
      IDX_DEACT_CODE: rd_byte = deact_code_reg;
      IDX_LOOP_STATUS: rd_byte = det_sync1_reg;
      IDX_LOOP_MASK: rd_byte = loop_mask_reg;
      IDX_LOOP_FLAG: rd_byte = loop_flag_reg;
      IDX_BANK_PTR: rd_byte = bank_ptr_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // One read under way; answer the cycle after the address
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_hit ? {24'h0, rd_byte} : 32'h0;
      s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ***********************************************
  // Datapath controls
  // ***********************************************
  // Global loopback controls for all channels
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      loop_ctrl_out <= '0;
    end else begin
      loop_ctrl_out.loop_code_detect_en <= loop_cfg_reg[LCFG_DETECT_BIT];
      loop_ctrl_out.auto_loop_en <= loop_cfg_reg[LCFG_AUTO_BIT];
      loop_ctrl_out.activate_code_mask <=
        len_mask(loop_cfg_reg[LCFG_ACT_LSB +: 2]);
      loop_ctrl_out.deactivate_code_mask <=
        len_mask(loop_cfg_reg[LCFG_DEACT_LSB +: 2]);
      loop_ctrl_out.activate_code_value <= act_code_reg;
      loop_ctrl_out.deactivate_code_value <= deact_code_reg;
    end
  end

  ebcc_chan_ctrl #(
    .HOLD_CYC(HOLD_CYC)
  ) u_chan_ctrl (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .cfg_in(cfg_reg),
    .tx_clock_pin_in(tx_clock_pin_in),
    .tx_negative_data_pin_in(tx_negative_data_pin_in),
    .ctrl_out(chan_ctrl_out)
  );

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_ptr_write(logic [7:0] val);
    do_write && wr_hit && w_lane0_reg && aw_addr_reg[6:2] == IDX_BANK_PTR && w_data_reg == val;
  endsequence

  property p_ptr_expanded;
    s_ptr_write(BANK_EXPANDED) |=> bank_expanded_out && bank_ptr_reg == BANK_EXPANDED;
  endproperty
  a_ptr_expanded: assert property (p_ptr_expanded) else $error("0xAA did not select");

  property p_ptr_primary;
    s_ptr_write(BANK_PRIMARY) |=> !bank_expanded_out && bank_ptr_reg == BANK_PRIMARY;
  endproperty
  a_ptr_primary: assert property (p_ptr_primary) else $error("0x00 did not select");

  property p_ptr_reset;
    $rose(rstn_in) |-> bank_ptr_reg == BANK_PRIMARY && !bank_expanded_out;
  endproperty
  a_ptr_reset: assert property (@(posedge clk_sys_in) p_ptr_reset) else $error("bad reset ptr");

  property p_ptr_legal;
    (bank_ptr_reg == BANK_PRIMARY || bank_ptr_reg == BANK_EXPANDED)
      && (bank_expanded_out == (bank_ptr_reg == BANK_EXPANDED));
  endproperty
  a_ptr_legal: assert property (p_ptr_legal) else $error("illegal bank pointer");

  sequence s_cfg_write;
    do_write && wr_hit && w_lane0_reg && bank_expanded_out && aw_addr_reg[6:2] == IDX_LOOP_CFG;
  endsequence

  property p_detect_en;
    s_cfg_write ##2 1'b1 |-> loop_ctrl_out.loop_code_detect_en == $past(w_data_reg[5], 2)
      && loop_ctrl_out.auto_loop_en == $past(w_data_reg[4], 2);
  endproperty
  a_detect_en: assert property (p_detect_en) else $error("loop enables lag");

  property p_act_mask;
    $past(rstn_in) && $past(loop_cfg_reg[3:2]) == 2'h0
      |-> loop_ctrl_out.activate_code_mask == 8'hF8;
  endproperty
  a_act_mask: assert property (p_act_mask) else $error("activate mask wrong");

  property p_deact_mask;
    $past(loop_cfg_reg[1:0]) == 2'h1 |-> loop_ctrl_out.deactivate_code_mask == 8'hFC;
  endproperty
  a_deact_mask: assert property (p_deact_mask) else $error("deactivate mask wrong");

  property p_flag_gate;
    ((loop_flag_reg & ~$past(loop_flag_reg))
      & ~($past(loop_mask_reg) & {8{$past(loop_cfg_reg[LCFG_DETECT_BIT])}})) == 8'h00;
  endproperty
  a_flag_gate: assert property (p_flag_gate) else $error("ungated loop flag");

  property p_write_resp;
    do_write |=> s_axi_bvalid_out;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("no write response");

  property p_resp_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
endmodule
